// ===== src/ssd_cfg.svh
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH

// register offsets
`define SSD_OFS_SETTLE   8'h15
`define SSD_OFS_ANALOG   8'h17
`define SSD_OFS_SWING    8'h18
`define SSD_OFS_STATUS   8'h1c

// reset values
`define SSD_RST_SETTLE   8'h00
`define SSD_RST_ANALOG   8'h83
`define SSD_RST_SWING    8'hc1

// writable bit masks (reserved bits read zero)
`define SSD_MSK_ANALOG   8'h97
`define SSD_MSK_SWING    8'hc7

// settle config fields
`define SSD_SEL_MSB      7
`define SSD_SEL_LSB      4
`define SSD_WIN_BIT      3
`define SSD_MODE_BIT     2
`define SSD_ACC_MSB      1
`define SSD_ACC_LSB      0

// analog config fields
`define SSD_BAND_BIT     7
`define SSD_PDL_BIT      4
`define SSD_BOOST_BIT    2
`define SSD_DIVB_MSB     1
`define SSD_DIVB_LSB     0

// swing config fields
`define SSD_PSW_MSB      7
`define SSD_PSW_LSB      6
`define SSD_TSW_MSB      2
`define SSD_TSW_LSB      0

// status source codes
`define SSD_SRC_HIGH     4'h1
`define SSD_SRC_SUST     4'h2
`define SSD_SRC_INST     4'h3
`define SSD_SRC_CAL      4'h5
`define SSD_SRC_XOSC     4'h7
`define SSD_SRC_REF      4'h8
`define SSD_SRC_PRE      4'hb
`define SSD_SRC_DS       4'hc
`define SSD_SRC_MODEM    4'hd
`define SSD_SRC_OSCCMP   4'he
`define SSD_SRC_FCMP     4'hf

// detector timing: windows in prescaler clock cycles, thresholds in comparisons
`define SSD_WIN_NARROW   4'h2
`define SSD_WIN_WIDE     4'h4
`define SSD_THR_BASE     10'h07f
`define SSD_HYST         10'h010

`endif

// ===== src/ssd_pkg.sv
`default_nettype none
package ssd_pkg;

  typedef enum logic [1:0] {
    SSD_UNSETTLED = 2'b01,
    SSD_SETTLED   = 2'b10
  } ssd_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ssd_bus_req_t;

  typedef struct packed {
    logic crystal_osc_clock;
    logic ref_clk;
    logic pre_clk;
    logic delta_sigma_clock_tap;
    logic modem_clk;
  } ssd_clk_taps_t;

  typedef struct packed {
    logic       band_choice;
    logic       phase_det_long_delay;
    logic       amp_bias_boost;
    logic [1:0] divider_buffer_bias;
    logic [1:0] prescaler_swing;
    logic [2:0] lo_buffer_swing;
  } ssd_analog_t;

endpackage
`default_nettype wire

// ===== src/ssd_top.sv
// Functional notes
// - select field is bits 7:4; codes 0,4,6,9,10 drive low, 1 drives high
// - code 2 gives sustained settle, code 3 instant settle, both active low
// - code 5 gives calibration done, active low
// - code 14 gives oscillator calibration comparator, code 15 frequency comparator
// - window bit 0 means 2 prescaler cycles wide, 1 means 4
// - counting bit 0 means restart mode, 1 means up/down counting
// - accuracy codes 0..3 declare at 127/255/511/1023, release at 111/239/495/1007
// - band bit 7: 0 lower band, 1 upper band; resets to 1
// - delay bit 0 short phase detector reset delay, 1 long
// - boost bit set raises amplifier bias current
// - divider bias codes 0..3 give 4/6, 4/5, nominal, 4/3; resets to 3
// - prescaler swing codes 0..3 give 2/3, 1/2, 4/3, nominal; resets to 3
// - buffer swing 0 smallest to 7 largest load resistance
//
// The strobed register port was chosen for this implementation.
`include "ssd_cfg.svh"
`default_nettype none

module ssd_top #(
  parameter int CNT_W = 10,
  parameter int ERR_W = 4
) (
  input  wire logic                  clk_sys_in,       // system clock
  input  wire logic                  srst_in,          // sync reset, high
  input  wire logic [7:0]            reg_addr_in,      // register address
  input  wire logic [7:0]            reg_wdata_in,     // write data
  input  wire logic                  reg_wr_in,        // write strobe
  input  wire logic                  reg_rd_in,        // read strobe
  output logic      [7:0]            reg_rdata_out,    // read data, cycle after read
  input  wire ssd_pkg::ssd_clk_taps_t clk_taps_in,     // internal clock levels
  input  wire logic                  cmp_strobe_in,    // one comparison done
  input  wire logic [ERR_W-1:0]      phase_err_in,     // error in prescaler cycles
  input  wire logic                  cal_done_in,      // calibration completed
  input  wire logic                  osc_calibration_comparator_in, // osc cal compare
  input  wire logic                  freq_comp_in,     // frequency comparator
  output logic                       status_pin_out,   // selected status level
  output logic                       settle_sustained_ind_out, // settled, high
  output ssd_pkg::ssd_analog_t       analog_out        // analog settings
);

  // elaboration checks: the counter must reach the top threshold, the error the wide window
  if (CNT_W < 10) begin : g_chk_cnt_w
    $error("CNT_W must hold 1023");
  end
  if (ERR_W < 3) begin : g_chk_err_w
    $error("ERR_W must hold 4");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  ssd_pkg::ssd_bus_req_t bus;
  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  logic [7:0]          settle_cfg_r;
  logic [7:0]          analog_cfg_r;
  logic [7:0]          swing_cfg_r;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic                instant_r;
  logic                pin_nxt;
  logic                in_win;
  logic [CNT_W-1:0]    thr_set;
  logic [CNT_W-1:0]    thr_rel;
  logic [3:0]          sel;
  ssd_pkg::ssd_state_t state_r;
  ssd_pkg::ssd_state_t state_nxt;

  // declare threshold: base value with one extra low one per accuracy step
  function automatic logic [CNT_W-1:0] thr_declare(input logic [1:0] acc);
    logic [CNT_W-1:0] d;
    d = CNT_W'(`SSD_THR_BASE);
    for (int i = 0; i < 3; i++) begin
      if (2'(i) < acc) d = {d[CNT_W-2:0], 1'b1};
    end
    return d;
  endfunction

  assign sel     = settle_cfg_r[`SSD_SEL_MSB:`SSD_SEL_LSB];
  assign thr_set = thr_declare(settle_cfg_r[`SSD_ACC_MSB:`SSD_ACC_LSB]);
  assign thr_rel = thr_set - CNT_W'(`SSD_HYST);

  // register writes; reserved bits are held at zero
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      settle_cfg_r <= `SSD_RST_SETTLE;
      analog_cfg_r <= `SSD_RST_ANALOG;
      swing_cfg_r  <= `SSD_RST_SWING;
    end else if (bus.wr) begin
      case (bus.addr)
        `SSD_OFS_SETTLE: settle_cfg_r <= bus.wdata;
        `SSD_OFS_ANALOG: analog_cfg_r <= bus.wdata & `SSD_MSK_ANALOG;
        `SSD_OFS_SWING:  swing_cfg_r  <= bus.wdata & `SSD_MSK_SWING;
        default: ;
      endcase
    end
  end

  // register reads; data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `SSD_OFS_SETTLE: reg_rdata_out <= settle_cfg_r;
        `SSD_OFS_ANALOG: reg_rdata_out <= analog_cfg_r;
        `SSD_OFS_SWING:  reg_rdata_out <= swing_cfg_r;
        `SSD_OFS_STATUS: reg_rdata_out <= {5'h00, cal_done_in, instant_r,
                                           state_r == ssd_pkg::SSD_SETTLED};
        default:         reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // analog settings come straight from the config flops
  assign analog_out.band_choice          = analog_cfg_r[`SSD_BAND_BIT];
  assign analog_out.phase_det_long_delay = analog_cfg_r[`SSD_PDL_BIT];
  assign analog_out.amp_bias_boost       = analog_cfg_r[`SSD_BOOST_BIT];
  assign analog_out.divider_buffer_bias  =
    analog_cfg_r[`SSD_DIVB_MSB:`SSD_DIVB_LSB];
  assign analog_out.prescaler_swing      =
    swing_cfg_r[`SSD_PSW_MSB:`SSD_PSW_LSB];
  assign analog_out.lo_buffer_swing      =
    swing_cfg_r[`SSD_TSW_MSB:`SSD_TSW_LSB];

  // comparison window test
  always_comb begin
    if (settle_cfg_r[`SSD_WIN_BIT]) begin
      in_win = phase_err_in < ERR_W'(`SSD_WIN_WIDE);
    end else begin
      in_win = phase_err_in < ERR_W'(`SSD_WIN_NARROW);
    end
  end

  // settle counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (cmp_strobe_in) begin
      if (in_win) begin
        if (cnt_r != CNT_MAX) cnt_nxt = cnt_r + 1'b1;
      end else if (settle_cfg_r[`SSD_MODE_BIT]) begin
        if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
      end else begin
        cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // sustained indication with hysteresis
  always_comb begin
    case (state_r)
      ssd_pkg::SSD_UNSETTLED: begin
        if (cnt_nxt >= thr_set) state_nxt = ssd_pkg::SSD_SETTLED;
        else state_nxt = ssd_pkg::SSD_UNSETTLED;
      end
      ssd_pkg::SSD_SETTLED: begin
        if (cnt_nxt <= thr_rel) state_nxt = ssd_pkg::SSD_UNSETTLED;
        else state_nxt = ssd_pkg::SSD_SETTLED;
      end
      default: state_nxt = ssd_pkg::SSD_UNSETTLED;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_r                  <= ssd_pkg::SSD_UNSETTLED;
      settle_sustained_ind_out <= 1'b0;
    end else begin
      state_r                  <= state_nxt;
      settle_sustained_ind_out <= state_nxt == ssd_pkg::SSD_SETTLED;
    end
  end

  // instant indication: count at or above declare, no hysteresis
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      instant_r <= 1'b0;
    end else begin
      instant_r <= cnt_nxt >= thr_set;
    end
  end

  // status pin source select
  always_comb begin
    case (sel)
      `SSD_SRC_HIGH:   pin_nxt = 1'b1;
      `SSD_SRC_SUST:   pin_nxt = state_r != ssd_pkg::SSD_SETTLED;
      `SSD_SRC_INST:   pin_nxt = !instant_r;
      `SSD_SRC_CAL:    pin_nxt = !cal_done_in;
      `SSD_SRC_XOSC:   pin_nxt = clk_taps_in.crystal_osc_clock;
      `SSD_SRC_REF:    pin_nxt = clk_taps_in.ref_clk;
      `SSD_SRC_PRE:    pin_nxt = clk_taps_in.pre_clk;
      `SSD_SRC_DS:     pin_nxt = clk_taps_in.delta_sigma_clock_tap;
      `SSD_SRC_MODEM:  pin_nxt = clk_taps_in.modem_clk;
      `SSD_SRC_OSCCMP: pin_nxt = osc_calibration_comparator_in;
      `SSD_SRC_FCMP:   pin_nxt = freq_comp_in;
      default:         pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      status_pin_out <= 1'b0;
    end else begin
      status_pin_out <= pin_nxt;
    end
  end

  // checks
  property p_src_low;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h0 || sel == 4'h4 || sel == 4'h6 || sel == 4'h9 || sel == 4'ha)
      |=> !status_pin_out;
  endproperty
  a_src_low: assert property (p_src_low) else $error("low source not low");

  property p_src_high;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h1) |=> status_pin_out;
  endproperty
  a_src_high: assert property (p_src_high) else $error("high source not high");

  property p_src_sust;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h2) |=> status_pin_out == !$past(settle_sustained_ind_out);
  endproperty
  a_src_sust: assert property (p_src_sust) else $error("sustained pin wrong");

  property p_src_cal;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h5) |=> status_pin_out == !$past(cal_done_in);
  endproperty
  a_src_cal: assert property (p_src_cal) else $error("cal done pin wrong");

  property p_src_ref;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h8) |=> status_pin_out == $past(clk_taps_in.ref_clk);
  endproperty
  a_src_ref: assert property (p_src_ref) else $error("ref clock pin wrong");

  property p_src_fcmp;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'hf) |=> status_pin_out == $past(freq_comp_in);
  endproperty
  a_src_fcmp: assert property (p_src_fcmp) else $error("freq comp pin wrong");

  property p_win_edge;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && phase_err_in == ERR_W'(2) && !settle_cfg_r[3] && !settle_cfg_r[2])
      |=> cnt_r == '0;
  endproperty
  a_win_edge: assert property (p_win_edge) else $error("narrow window too wide");

  property p_down;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && !in_win && settle_cfg_r[2] && cnt_r != '0)
      |=> cnt_r == $past(cnt_r) - 1'b1;
  endproperty
  a_down: assert property (p_down) else $error("up/down did not decrement");

  property p_up;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && in_win && cnt_r != CNT_MAX) |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_up: assert property (p_up) else $error("counter did not increment");

  property p_declare;
    @(posedge clk_sys_in) disable iff (srst_in)
    (settle_cfg_r[1:0] == 2'h0 && cnt_r == CNT_W'(126) && cmp_strobe_in && in_win)
      |=> settle_sustained_ind_out;
  endproperty
  a_declare: assert property (p_declare) else $error("no declare at 127");

  property p_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
    // a restart-mode clear may legally drop the count below release in one step
    (settle_sustained_ind_out && cnt_r > thr_rel + 1'b1 && (settle_cfg_r[2] || !cmp_strobe_in || in_win))
      |=> settle_sustained_ind_out;
  endproperty
  a_hold: assert property (p_hold) else $error("released above release count");

  property p_band_rst;
    @(posedge clk_sys_in)
    srst_in |=> analog_out.band_choice && analog_out.divider_buffer_bias == 2'h3;
  endproperty
  a_band_rst: assert property (p_band_rst) else $error("analog reset value wrong");

  property p_src_inst;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h3) |=> status_pin_out == !$past(instant_r);
  endproperty
  a_src_inst: assert property (p_src_inst) else $error("instant pin wrong");

  property p_src_xosc;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'h7) |=> status_pin_out == $past(clk_taps_in.crystal_osc_clock);
  endproperty
  a_src_xosc: assert property (p_src_xosc) else $error("crystal clock pin wrong");

  property p_src_pre;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'hb) |=> status_pin_out == $past(clk_taps_in.pre_clk);
  endproperty
  a_src_pre: assert property (p_src_pre) else $error("prescaler clock pin wrong");

  property p_src_osccmp;
    @(posedge clk_sys_in) disable iff (srst_in)
    (sel == 4'he) |=> status_pin_out == $past(osc_calibration_comparator_in);
  endproperty
  a_src_osccmp: assert property (p_src_osccmp) else $error("osc comparator pin wrong");

  property p_win_wide;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && phase_err_in == ERR_W'(3) && settle_cfg_r[3] && cnt_r != CNT_MAX)
      |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_win_wide: assert property (p_win_wide) else $error("wide window too narrow");

  property p_win_wide_out;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && phase_err_in == ERR_W'(4) && settle_cfg_r[3] && !settle_cfg_r[2])
      |=> cnt_r == '0;
  endproperty
  a_win_wide_out: assert property (p_win_wide_out) else $error("wide window too wide");

  property p_restart_clr;
    @(posedge clk_sys_in) disable iff (srst_in)
    (cmp_strobe_in && !in_win && !settle_cfg_r[2]) |=> cnt_r == '0;
  endproperty
  a_restart_clr: assert property (p_restart_clr) else $error("restart mode did not clear");

  property p_declare_max;
    @(posedge clk_sys_in) disable iff (srst_in)
    (settle_cfg_r[1:0] == 2'h3 && cnt_r == CNT_W'(1022) && cmp_strobe_in && in_win)
      |=> settle_sustained_ind_out;
  endproperty
  a_declare_max: assert property (p_declare_max) else $error("no declare at 1023");

  property p_release;
    @(posedge clk_sys_in) disable iff (srst_in)
    (settle_sustained_ind_out && cmp_strobe_in && !in_win && settle_cfg_r[2] && cnt_r == thr_rel + 1'b1)
      |=> !settle_sustained_ind_out;
  endproperty
  a_release: assert property (p_release) else $error("no release at release count");

endmodule
`default_nettype wire

// ===== tb/ssd_host_model.sv
`default_nettype none
// host side watcher of the status pin: counts rising transitions so routed clocks can be seen
module ssd_host_model (
  input  wire logic       clk_sys_in,    // system clock
  input  wire logic       srst_in,       // sync reset, high
  input  wire logic       status_pin_in, // status pin level
  output logic      [7:0] rises_out      // count of pin rises
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pin_d_r;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pin_d_r   <= 1'b0;
      rises_out <= 8'h00;
    end else begin
      pin_d_r <= status_pin_in;
      if (status_pin_in && !pin_d_r) begin
        rises_out <= rises_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/synth_settle_detect_config_bench.sv
`default_nettype none
module synth_settle_detect_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] code;
    logic [4:0] taps;
    logic [2:0] lvl;
    logic       exp;
  } ssd_row_t;
  logic                   clk_sys_in;
  logic                   srst_in;
  logic [7:0]             reg_addr_in;
  logic [7:0]             reg_wdata_in;
  logic                   reg_wr_in;
  logic                   reg_rd_in;
  logic [7:0]             reg_rdata_out;
  ssd_pkg::ssd_clk_taps_t clk_taps_in;
  logic                   cmp_strobe_in;
  logic [3:0]             phase_err_in;
  logic                   cal_done_in;
  logic                   osc_cmp;
  logic                   freq_comp_in;
  logic                   status_pin_out;
  logic                   sust;
  ssd_pkg::ssd_analog_t   analog_out;
  logic [7:0]             pin_rises;
  ssd_row_t               rows [24];
  int                     n_mismatch = 0;
  int                     checks = 0;
  int                     cycles = 0;
  logic [7:0]             base;
  logic [9:0]             decl;
  logic [3:0]             e_in;
  logic [3:0]             e_out;

  ssd_top i_ssd_top (
    .clk_sys_in                    (clk_sys_in),
    .srst_in                       (srst_in),
    .reg_addr_in                   (reg_addr_in),
    .reg_wdata_in                  (reg_wdata_in),
    .reg_wr_in                     (reg_wr_in),
    .reg_rd_in                     (reg_rd_in),
    .reg_rdata_out                 (reg_rdata_out),
    .clk_taps_in                   (clk_taps_in),
    .cmp_strobe_in                 (cmp_strobe_in),
    .phase_err_in                  (phase_err_in),
    .cal_done_in                   (cal_done_in),
    .osc_calibration_comparator_in (osc_cmp),
    .freq_comp_in                  (freq_comp_in),
    .status_pin_out                (status_pin_out),
    .settle_sustained_ind_out      (sust),
    .analog_out                    (analog_out)
  );

  ssd_host_model i_ssd_host_model (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .status_pin_in (status_pin_out),
    .rises_out     (pin_rises)
  );

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_ana(input string name, input ssd_pkg::ssd_analog_t exp, input ssd_pkg::ssd_analog_t got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk_byte("rdata", exp, reg_rdata_out);
  endtask

  // n back-to-back comparisons with the given error; returns just after the last one lands
  task automatic strobes(input int n, input logic [3:0] e);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_in);
      cmp_strobe_in <= 1'b1;
      phase_err_in  <= e;
    end
    @(posedge clk_sys_in);
    cmp_strobe_in <= 1'b0;
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    srst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    clk_taps_in = '0;
    cmp_strobe_in = 1'b0;
    phase_err_in = 4'h0;
    {cal_done_in, osc_cmp, freq_comp_in} = 3'h0;
    // code, clock taps, {cal done, osc comparator, freq comparator}, expected pin
    rows = '{'{4'h0, 5'h1f, 3'h7, 1'h0}, '{4'h1, 5'h00, 3'h0, 1'h1}, '{4'h4, 5'h1f, 3'h7, 1'h0},
             '{4'h6, 5'h1f, 3'h7, 1'h0}, '{4'h9, 5'h1f, 3'h7, 1'h0}, '{4'ha, 5'h1f, 3'h7, 1'h0},
             '{4'h2, 5'h00, 3'h0, 1'h1}, '{4'h3, 5'h00, 3'h0, 1'h1}, '{4'h5, 5'h00, 3'h4, 1'h0},
             '{4'h5, 5'h1f, 3'h3, 1'h1}, '{4'h7, 5'h10, 3'h0, 1'h1}, '{4'h7, 5'h0f, 3'h7, 1'h0},
             '{4'h8, 5'h08, 3'h0, 1'h1}, '{4'h8, 5'h17, 3'h7, 1'h0}, '{4'hb, 5'h04, 3'h0, 1'h1},
             '{4'hb, 5'h1b, 3'h7, 1'h0}, '{4'hc, 5'h02, 3'h0, 1'h1}, '{4'hc, 5'h1d, 3'h7, 1'h0},
             '{4'hd, 5'h01, 3'h0, 1'h1}, '{4'hd, 5'h1e, 3'h7, 1'h0}, '{4'he, 5'h00, 3'h2, 1'h1},
             '{4'he, 5'h1f, 3'h5, 1'h0}, '{4'hf, 5'h00, 3'h1, 1'h1}, '{4'hf, 5'h1f, 3'h6, 1'h0}};
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk_ana("analog", {1'h1, 1'h0, 1'h0, 2'h3, 2'h3, 3'h1}, analog_out);
    rd(8'h15, 8'h00);
    rd(8'h17, 8'h83);
    rd(8'h18, 8'hc1);
    rd(8'h20, 8'h00);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    wr(8'h17, 8'h15);
    wr(8'h18, 8'h84);
    #1;
    chk_ana("analog", {1'h0, 1'h1, 1'h1, 2'h1, 2'h2, 3'h4}, analog_out);
    rd(8'h17, 8'h15);
    rd(8'h18, 8'h84);
    // reserved bits written as one read back zero; analog spare bit 3 is still written zero
    wr(8'h17, 8'hf7);
    wr(8'h18, 8'hff);
    #1;
    chk_ana("analog", {1'h1, 1'h1, 1'h1, 2'h3, 2'h3, 3'h7}, analog_out);
    rd(8'h17, 8'h97);
    rd(8'h18, 8'hc7);
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      clk_taps_in <= rows[i].taps;
      {cal_done_in, osc_cmp, freq_comp_in} <= rows[i].lvl;
      wr(8'h15, {rows[i].code, 4'h0});
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk_bit("status_pin", rows[i].exp, status_pin_out);
    end
    @(posedge clk_sys_in);
    clk_taps_in <= '0;
    {cal_done_in, osc_cmp, freq_comp_in} <= 3'h0;
    wr(8'h15, 8'hb0);
    repeat (3) @(posedge clk_sys_in);
    #1;
    base = pin_rises;
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_sys_in);
      clk_taps_in.pre_clk <= ~clk_taps_in.pre_clk;
    end
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk_byte("pin_rises", base + 8'h05, pin_rises);
    for (int a = 0; a < 4; a++) begin
      decl = 10'((128 << a) - 1);
      e_in = a[0] ? 4'h3 : 4'h1;
      e_out = a[0] ? 4'h4 : 4'h2;
      wr(8'h15, {4'h2, a[0], 1'b0, a[1:0]});
      strobes(1, e_out);
      chk_bit("sustained", 1'h0, sust);
      wr(8'h15, {4'h2, a[0], 1'b1, a[1:0]});
      strobes(decl - 1, e_in);
      chk_bit("sustained", 1'h0, sust);
      strobes(1, e_in);
      chk_bit("sustained", 1'h1, sust);
      @(posedge clk_sys_in);
      #1;
      chk_bit("status_pin", 1'h0, status_pin_out);
      rd(8'h1c, 8'h03);
      wr(8'h15, {4'h3, a[0], 1'b1, a[1:0]});
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk_bit("status_pin", 1'h0, status_pin_out);
      strobes(15, e_out);
      chk_bit("sustained", 1'h1, sust);
      rd(8'h1c, 8'h01);
      strobes(1, e_out);
      chk_bit("sustained", 1'h0, sust);
    end
    wr(8'h15, 8'h20);
    strobes(1, 4'h2);
    strobes(127, 4'h1);
    chk_bit("sustained", 1'h1, sust);
    strobes(1, 4'h2);
    chk_bit("sustained", 1'h0, sust);
    // settle again so that the mid-run reset has something to clear
    strobes(127, 4'h1);
    chk_bit("sustained", 1'h1, sust);
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk_ana("analog", {1'h1, 1'h0, 1'h0, 2'h3, 2'h3, 3'h1}, analog_out);
    chk_bit("sustained", 1'h0, sust);
    chk_bit("status_pin", 1'h0, status_pin_out);
    rd(8'h15, 8'h00);
    rd(8'h1c, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
